// ===== bench/rpes_host.sv
// host gpio model driving the two power-request pins
`timescale 1ns/10ps
module rpes_host #(
    parameter int LOW_CYCLES = 8,
    parameter int WAIT_CYCLES = 30
) (
    input wire logic core_clk,
    input wire logic supplies_up,
    input wire logic wlan_cmd,
    input wire logic short_cmd,
    output logic wlan_power_request,
    output logic short_radio_power_request,
    output logic bus_allowed
);
    int low_cnt = 0;
    int up_cnt = 0;
    initial
    begin
        wlan_power_request = 1'b0;
        short_radio_power_request = 1'b0;
    end
    // a pending low time only delays a raise, never shortens it
    always @(negedge core_clk)
    begin
        if (wlan_power_request || short_radio_power_request)
            low_cnt <= 0;
        else if (low_cnt < LOW_CYCLES)
            low_cnt <= low_cnt + 1;
        if (wlan_power_request || short_radio_power_request || low_cnt >= LOW_CYCLES)
        begin
            wlan_power_request <= wlan_cmd;
            short_radio_power_request <= short_cmd;
        end
        up_cnt <= supplies_up ? up_cnt + 1 : 0;
    end
    assign bus_allowed = up_cnt >= WAIT_CYCLES;
endmodule

// ===== bench/rpes_seq_test.sv
// self-checking bench for the radio power-enable sequencer
`timescale 1ns/10ps
module rpes_seq_test;
    localparam int POR = 20;
    localparam int LOW = 8;
    logic core_clk = 0;
    logic rst_n = 0;
    logic core_supply_good = 1;
    logic io_supply_good = 1;
    logic wlan_cmd = 0;
    logic short_cmd = 0;
    logic wlan_power_request, short_radio_power_request, bus_allowed;
    logic core_buck_regulator_en, wlan_reset_n, short_radio_reset_n, device_por_n;
    int err_count = 0;
    int compares = 0;
    int n;
    rpes_host #(.LOW_CYCLES(LOW), .WAIT_CYCLES(POR + 10)) u_rpes_host (.core_clk(core_clk),
        .supplies_up(core_buck_regulator_en & core_supply_good & io_supply_good),
        .wlan_cmd(wlan_cmd), .short_cmd(short_cmd), .wlan_power_request(wlan_power_request),
        .short_radio_power_request(short_radio_power_request), .bus_allowed(bus_allowed));
    rpes_seq #(.POR_CYCLES(POR)) u_rpes_seq (.core_clk(core_clk), .rst_n(rst_n),
        .core_supply_good(core_supply_good), .io_supply_good(io_supply_good),
        .wlan_power_request(wlan_power_request), .short_radio_power_request(short_radio_power_request),
        .core_buck_regulator_en(core_buck_regulator_en), .wlan_reset_n(wlan_reset_n),
        .short_radio_reset_n(short_radio_reset_n), .device_por_n(device_por_n));
    initial
        forever #2.5 core_clk = ~core_clk;
    task step(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task check(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask
    task stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task scen_wlan_only();
        wlan_cmd <= 1'b1;
        step(3);
        check(core_buck_regulator_en, 1'b1, "regulator off with wlan request");
        check(wlan_reset_n, 1'b0, "wlan released before power-on reset");
        n = 0;
        while (device_por_n !== 1'b1 && n < POR + 6)
        begin
            step(1);
            n++;
        end
        check(device_por_n, 1'b1, "power-on reset not released in time");
        check(bus_allowed, 1'b0, "host bus opened before its wait");
        step(2);
        check(wlan_reset_n, 1'b1, "wlan held with request high");
        check(short_radio_reset_n, 1'b0, "short radio released without request");
    endtask
    task scen_swap();
        short_cmd <= 1'b1;
        step(3);
        check(short_radio_reset_n, 1'b1, "short radio held with request high");
        wlan_cmd <= 1'b0;
        step(3);
        check(core_buck_regulator_en, 1'b1, "regulator off with short request");
        check(wlan_reset_n, 1'b0, "wlan released with request low");
        check(device_por_n, 1'b1, "power-on reset restarted");
    endtask
    task scen_cycle();
        short_cmd <= 1'b0;
        step(3);
        check(core_buck_regulator_en, 1'b0, "regulator on with both low");
        check(device_por_n, 1'b0, "power-on reset kept after power off");
        wlan_cmd <= 1'b1;
        step(LOW - 2);
        check(core_buck_regulator_en, 1'b0, "regulator on inside host low time");
        step(7);
        check(core_buck_regulator_en, 1'b1, "regulator off after low time");
        n = 0;
        while (device_por_n !== 1'b1 && n < POR + 6)
        begin
            step(1);
            n++;
        end
        check(device_por_n, 1'b1, "power-on reset not released after power cycle");
        io_supply_good <= 1'b0;
        step(3);
        check(device_por_n, 1'b0, "power-on reset kept after supply drop");
        check(wlan_reset_n, 1'b0, "wlan released after supply drop");
        io_supply_good <= 1'b1;
        core_supply_good <= 1'b0;
        step(POR + 6);
        check(device_por_n, 1'b0, "power-on reset ran without core supply");
    endtask
    initial
    begin
        step(5);
        check(core_buck_regulator_en, 1'b0, "regulator on in reset");
        rst_n = 1'b1;
        step(2);
        scen_wlan_only();
        scen_swap();
        scen_cycle();
        stop_test();
    end
endmodule

// ===== rtl/rpes_consts.svh
// timing constants for the radio power-enable sequencer
`ifndef RPES_CONSTS_SVH
`define RPES_CONSTS_SVH
`define RPES_CLK_MHZ 200
`define RPES_POR_MAX_MS 110
`define RPES_POR_CYCLES (`RPES_POR_MAX_MS * 1000 * `RPES_CLK_MHZ)
`define RPES_RAIL_GOOD_BIT 0
`define RPES_REG_EN_RESET 1'b0
`endif

// ===== rtl/rpes_gate.sv
// combinational enable and section-release decode
`timescale 1ns/10ps
module rpes_gate (
    rpes_req_if.gate req
);
    // either request keeps the rails up
    assign req.next_reg_en = req.wlan_req | req.short_req;
    assign req.next_wlan_run = req.wlan_req & req.por_done;
    assign req.next_short_run = req.short_req & req.por_done;
endmodule

// ===== rtl/rpes_pkg.sv
// types shared by the radio power-enable sequencer
package rpes_pkg;
    typedef enum logic [1:0] {
        RPES_OFF,
        RPES_POR_WAIT,
        RPES_RUN
    } rpes_state_type;
endpackage

// ===== rtl/rpes_req_if.sv
// request and reset-release bundle between the sequencer and its gate
`timescale 1ns/10ps
interface rpes_req_if;
    logic wlan_req;
    logic short_req;
    logic por_done;
    logic next_wlan_run;
    logic next_short_run;
    logic next_reg_en;
    modport seq (output wlan_req, output short_req, output por_done,
                 input next_wlan_run, input next_short_run, input next_reg_en);
    modport gate (input wlan_req, input short_req, input por_done,
                  output next_wlan_run, output next_short_run, output next_reg_en);
endinterface

// ===== rtl/rpes_seq.sv
// power-enable and reset sequencer for the two radio sections
`timescale 1ns/10ps
`include "rpes_consts.svh"
// Contract
// - regulators on when either request high
// - wlan reset follows wlan request level; release also waits for power-on reset to end
// - regulators off when both requests low
// - short radio reset while its request low
// - power-on reset releases within 110 ms
module rpes_seq
    import rpes_pkg::*;
#(
    parameter int unsigned POR_CYCLES = `RPES_POR_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic core_supply_good,
    input wire logic io_supply_good,
    input wire logic wlan_power_request,
    input wire logic short_radio_power_request,
    output logic core_buck_regulator_en,
    output logic wlan_reset_n,
    output logic short_radio_reset_n,
    output logic device_por_n
);
    // a zero hold would let the sections out before the rails settle
    if (POR_CYCLES < 1)
    begin
        $error("POR_CYCLES must be at least one");
    end

    rpes_req_if req();
    rpes_gate u_gate (
        .req(req)
    );

    rpes_state_type state;
    rpes_state_type next_state;
    logic [31:0] por_count;
    logic [31:0] next_por_count;
    wire logic rails_good;
    wire logic rails_on;
    wire logic por_expired;
    wire logic rails_lost;

    // both supplies must be past threshold; only meaningful with rails on
    assign rails_good = core_supply_good & io_supply_good;
    assign rails_on = core_buck_regulator_en;
    assign por_expired = (por_count >= POR_CYCLES - 1);
    // a dropped rail or regulator sends the sequencer back to off
    assign rails_lost = !rails_on || !rails_good;
    assign req.wlan_req = wlan_power_request;
    assign req.short_req = short_radio_power_request;
    assign req.por_done = (state == RPES_RUN);

    always_comb
    begin
        next_state = state;
        next_por_count = por_count;
        case (state)
            RPES_OFF:
            begin
                next_por_count = 32'h0;
                if (rails_on && rails_good)
                    next_state = RPES_POR_WAIT;
            end
            RPES_POR_WAIT:
            begin
                // counter bounds the internal reset hold
                next_por_count = por_count + 32'h1;
                if (rails_lost)
                    next_state = RPES_OFF;
                else if (por_expired)
                    next_state = RPES_RUN;
            end
            RPES_RUN:
            begin
                // losing a rail restarts the whole power-on reset
                if (rails_lost)
                    next_state = RPES_OFF;
            end
            default:
                next_state = RPES_OFF;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= RPES_OFF;
            por_count <= 32'h0;
        end
        else
        begin
            state <= next_state;
            por_count <= next_por_count;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_buck_regulator_en <= `RPES_REG_EN_RESET;
            wlan_reset_n <= 1'b0;
            short_radio_reset_n <= 1'b0;
            device_por_n <= 1'b0;
        end
        else
        begin
            core_buck_regulator_en <= req.next_reg_en;
            // one cycle late: outputs stay registered
            wlan_reset_n <= req.next_wlan_run;
            short_radio_reset_n <= req.next_short_run;
            device_por_n <= (next_state == RPES_RUN);
        end
    end

    // helper: cycles spent waiting since rails came good
    logic [31:0] hold_count;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            hold_count <= 32'h0;
        else if (state == RPES_POR_WAIT)
            hold_count <= hold_count + 32'h1;
        else
            hold_count <= 32'h0;
    end

    chk_regulator_or: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wlan_power_request || short_radio_power_request) |=> core_buck_regulator_en)
        else $error("regulators not enabled with a request high");

    chk_regulator_off: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!wlan_power_request && !short_radio_power_request) |=> !core_buck_regulator_en)
        else $error("regulators still on with both requests low");

    chk_wlan_low_reset: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !wlan_power_request |=> !wlan_reset_n)
        else $error("wlan released while its request low");

    chk_wlan_release: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wlan_power_request && state == RPES_RUN && rails_good && rails_on) |=> wlan_reset_n)
        else $error("wlan not released with request high");

    chk_short_held: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!short_radio_power_request && wlan_power_request) |=> !short_radio_reset_n)
        else $error("short radio released while its request low");

    chk_por_bound: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state == RPES_POR_WAIT) |-> (hold_count < POR_CYCLES))
        else $error("power-on reset held past its bound");

    chk_por_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(device_por_n) |-> (hold_count == POR_CYCLES))
        else $error("device released before power-on reset ended");

    chk_release_drop: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $fell(rails_good) |=> !device_por_n)
        else $error("device not reset after supply loss");

    chk_short_low_reset: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !short_radio_power_request |=> !short_radio_reset_n)
        else $error("short radio released with its request low");

    chk_short_release: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (short_radio_power_request && device_por_n) |=> short_radio_reset_n)
        else $error("short radio not released with request high");

    chk_sections_por: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !device_por_n |=> (!wlan_reset_n && !short_radio_reset_n))
        else $error("section released during power-on reset");

    chk_por_run_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (device_por_n && rails_on && rails_good) |=> device_por_n)
        else $error("device reset with rails steady");

    chk_por_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !rails_on |=> !device_por_n)
        else $error("device released with regulators off");

    chk_por_power_off: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!wlan_power_request && !short_radio_power_request) |-> ##2 !device_por_n)
        else $error("device not reset after both requests low");

    chk_por_from_off: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(device_por_n) |-> ($past(state) == RPES_POR_WAIT))
        else $error("device released without a power-on wait");

    cov_both_on: cover property (@(posedge core_clk) disable iff (!rst_n)
        wlan_reset_n && short_radio_reset_n);

    cov_wlan_only: cover property (@(posedge core_clk) disable iff (!rst_n)
        wlan_reset_n && !short_radio_reset_n);

    cov_short_only: cover property (@(posedge core_clk) disable iff (!rst_n)
        !wlan_reset_n && short_radio_reset_n);

    cov_power_cycle: cover property (@(posedge core_clk) disable iff (!rst_n)
        $fell(core_buck_regulator_en) ##[1:20] core_buck_regulator_en);

    cov_supply_drop: cover property (@(posedge core_clk) disable iff (!rst_n)
        device_por_n && !rails_good);
endmodule
